// ===== logic/wdt_defs.svh
/*
  Constants for the watchdog / interval timer: widths, reset values,
  feed sequence bytes and clock figures.
  Assumes it is included by the package and by the timer module only.
*/
// What this block does
// R1 - in watchdog mode an unfed underflow requests a full system reset
// R2 - twelve-bit programmable prescaler followed by an eight-bit down counter
// R3 - counter steps once per pulse from a selected prescaler tap
// R4 - prescaler clock is peripheral clock or the 400 kHz watchdog oscillator
// R5 - only power-on reset returns state and configuration to defaults
// R6 - with reset function off, expiry raises an interrupt request instead
// R7 - a feed counts only after the complete two-byte write sequence
// R8 - peripheral clock selected and processor powered down: stop, no reset
// R9 - reset mode when the mode enable bit is one, else interval timer
// R10 - peripheral clock runs at half the processor core clock
// R11 - valid feed reloads the counter and restarts the prescaler
// R12 - interval underflow sets a sticky flag, counter reloads and continues
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_PRE_W        12
`define WDT_CNT_W        8
`define WDT_TAP_W        4
`define WDT_PRE_RESET    12'h000
`define WDT_CNT_RESET    8'hFF
`define WDT_FEED_FIRST   8'hA5
`define WDT_FEED_SECOND  8'h5A
`define WDT_TAP_MAX      4'hB
`define WDT_SYS_CLK_KHZ  40000
`define WDT_OSC_KHZ      400

`endif

// ===== logic/wdt_pkg.sv
/*
  Types for the watchdog / interval timer.
  Assumes wdt_defs.svh is on the include path.
*/
`include "wdt_defs.svh"

package wdt_pkg;

    // feed sequencer, gray along idle -> first byte seen
    typedef enum logic [1:0] {
        FEED_IDLE  = 2'b00,
        FEED_FIRST = 2'b01
    } feed_state_t;

    typedef struct packed {
        logic                  reset_mode;
        logic                  osc_sel;
        logic [`WDT_TAP_W-1:0] tap_sel;
        logic [`WDT_CNT_W-1:0] reload;
    } wdt_cfg_t;

    typedef struct packed {
        logic                  strobe;
        logic [7:0]            data;
    } feed_wr_t;

endpackage

// ===== logic/watchdog_interval_timer.sv
/*
  Watchdog / interval timer: 12-bit prescaler, 8-bit down counter,
  two-byte feed, reset request or sticky interval flag on underflow.
  Assumes rst_n is the power-on reset only; core_clk_tick is a one-cycle
  pulse per processor core clock in the sys_clk domain; the watchdog
  oscillator pin is asynchronous and far slower than sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module watchdog_interval_timer
    import wdt_pkg::*;
(
    // clock and power-on reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // clock sources
    input  wire logic                  core_clk_tick,
    input  wire logic                  wdosc_pin,
    input  wire logic                  power_down,
    // configuration
    input  wire logic                  watchdog_reset_mode_enable,
    input  wire logic                  osc_sel,
    input  wire logic [`WDT_TAP_W-1:0] tap_sel,
    input  wire logic [`WDT_CNT_W-1:0] reload_value,
    input  wire logic                  cfg_write,
    // feed writes
    input  wire logic                  feed_strobe,
    input  wire logic [7:0]            feed_data,
    // status
    input  wire logic                  flag_clear,
    output logic                       system_reset_req,
    output logic                       interval_irq,
    output logic [`WDT_CNT_W-1:0]      count_value,
    output logic                       running
);

    // tap reached when all prescaler bits up to the tap are ones
    function automatic logic tap_hit(input logic [`WDT_PRE_W-1:0] pre,
                                     input logic [`WDT_TAP_W-1:0] sel);
        logic [`WDT_PRE_W-1:0] mask;
        logic [`WDT_TAP_W-1:0] s;
        s = (sel > `WDT_TAP_MAX) ? `WDT_TAP_MAX : sel;
        mask = {`WDT_PRE_W{1'b1}} >> (`WDT_TAP_MAX - s);
        tap_hit = ((pre & mask) == mask);
    endfunction

    // configuration, held through every reset except power-on
    wdt_cfg_t cfg_reg;
    wdt_cfg_t cfg_next;
    wdt_cfg_t cfg_in;

    assign cfg_in.reset_mode = watchdog_reset_mode_enable;
    assign cfg_in.osc_sel    = osc_sel;
    assign cfg_in.tap_sel    = tap_sel;
    assign cfg_in.reload     = reload_value;
    assign cfg_next          = cfg_write ? cfg_in : cfg_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin // R5
            cfg_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // peripheral clock: every second core clock
    logic pclk_phase_reg;
    logic pclk_phase_next;
    wire  pclk_tick;

    assign pclk_tick       = core_clk_tick & pclk_phase_reg; // R10
    assign pclk_phase_next = core_clk_tick ? ~pclk_phase_reg : pclk_phase_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pclk_phase_reg <= 1'b0;
        end else begin
            pclk_phase_reg <= pclk_phase_next;
        end
    end

    // oscillator pin: three flops, a rising change counts when stages 2 and 3 agree
    logic [2:0] osc_sync_reg;
    logic       osc_level_reg;
    logic       osc_level_next;
    wire        osc_agree;
    wire        osc_tick;

    assign osc_agree      = (osc_sync_reg[1] == osc_sync_reg[2]);
    assign osc_level_next = osc_agree ? osc_sync_reg[2] : osc_level_reg;
    assign osc_tick       = osc_agree & osc_sync_reg[2] & ~osc_level_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            osc_sync_reg  <= 3'h0;
            osc_level_reg <= 1'b0;
        end else begin
            osc_sync_reg  <= {osc_sync_reg[1:0], wdosc_pin};
            osc_level_reg <= osc_level_next;
        end
    end

    // source selection and power-down gating
    wire halted;
    wire src_tick;

    // oscillator source keeps counting in power-down; only the
    // peripheral clock path stops, since that clock is gone then
    assign halted   = power_down & ~cfg_reg.osc_sel; // R8
    assign src_tick = halted ? 1'b0 : (cfg_reg.osc_sel ? osc_tick : pclk_tick); // R4

    // feed sequence
    feed_wr_t    feed_in;
    feed_state_t feed_state_reg;
    feed_state_t feed_state_next;
    wire         feed_ok;

    // a feed in the underflow cycle wins, so a late but valid feed
    // still suppresses both the reset request and the interval flag
    assign feed_in.strobe = feed_strobe;
    assign feed_in.data   = feed_data;
    assign feed_ok = feed_in.strobe & (feed_state_reg == FEED_FIRST)
                   & (feed_in.data == `WDT_FEED_SECOND); // R7

    always_comb begin
        feed_state_next = feed_state_reg;
        case (feed_state_reg)
            FEED_IDLE: begin
                if (feed_in.strobe && feed_in.data == `WDT_FEED_FIRST) begin
                    feed_state_next = FEED_FIRST;
                end
            end
            FEED_FIRST: begin
                // a second write ends the sequence, good or not, unless it is A5 again
                if (feed_in.strobe) begin
                    feed_state_next = (feed_in.data == `WDT_FEED_FIRST) ? FEED_FIRST : FEED_IDLE; // R7
                end
            end
            default: begin
                feed_state_next = FEED_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            feed_state_reg <= FEED_IDLE;
        end else begin
            feed_state_reg <= feed_state_next;
        end
    end

    // prescaler and down counter
    logic [`WDT_PRE_W-1:0] pre_reg;
    logic [`WDT_PRE_W-1:0] pre_next;
    logic [`WDT_CNT_W-1:0] cnt_reg;
    logic [`WDT_CNT_W-1:0] cnt_next;
    wire                   tap_pulse;
    wire                   underflow;

    // prescaler free-runs; the tap only decides when the counter steps
    assign tap_pulse = src_tick & tap_hit(pre_reg, cfg_reg.tap_sel); // R3
    assign underflow = tap_pulse & (cnt_reg == '0);

    always_comb begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        if (feed_ok) begin
            pre_next = `WDT_PRE_RESET; // R11
            cnt_next = cfg_reg.reload; // R11
        end else if (src_tick) begin
            pre_next = pre_reg + `WDT_PRE_W'(1); // R2
            if (underflow) begin
                cnt_next = cfg_reg.reload; // R12
            end else if (tap_pulse) begin
                cnt_next = cnt_reg - `WDT_CNT_W'(1); // R2
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin // R5
            pre_reg <= `WDT_PRE_RESET;
            cnt_reg <= `WDT_CNT_RESET;
        end else begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
        end
    end

    // reset request or sticky interval flag; set beats clear
    logic reset_req_reg;
    logic reset_req_next;
    logic flag_reg;
    logic flag_next;
    logic running_reg;

    assign reset_req_next = underflow & ~feed_ok & cfg_reg.reset_mode; // R1 R9
    assign flag_next = (underflow & ~feed_ok & ~cfg_reg.reset_mode)
                     | (flag_reg & ~flag_clear); // R6 R12

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reset_req_reg <= 1'b0;
            flag_reg      <= 1'b0;
            running_reg   <= 1'b0;
        end else begin
            reset_req_reg <= reset_req_next;
            flag_reg      <= flag_next;
            running_reg   <= ~halted;
        end
    end

    assign system_reset_req = reset_req_reg;
    assign interval_irq     = flag_reg;
    assign count_value      = cnt_reg;
    assign running          = running_reg;

endmodule

`default_nettype wire

// ===== sim/wdt_checker_sva.sv
/*
  Checker for the watchdog / interval timer, bound to its top module.
  Assumes only the top module's ports are visible.
*/
`timescale 1ns/1ps
`default_nettype none

module wdt_checker (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // inputs
    input wire logic       power_down,
    input wire logic       watchdog_reset_mode_enable,
    input wire logic [7:0] reload_value,
    input wire logic       cfg_write,
    input wire logic       feed_strobe,
    input wire logic [7:0] feed_data,
    input wire logic       flag_clear,
    // outputs
    input wire logic       system_reset_req,
    input wire logic       interval_irq,
    input wire logic [7:0] count_value,
    input wire logic       running
);
    logic       mode_reg;
    logic [7:0] reload_reg;

    // shadow of the latched configuration
    always_ff @(posedge sys_clk)
        if (!rst_n) {mode_reg, reload_reg} <= '0;
        else if (cfg_write) {mode_reg, reload_reg} <= {watchdog_reset_mode_enable, reload_value};

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_RST_PULSE: assert property (system_reset_req |=> !system_reset_req)
        else $error("reset request longer than one cycle");
    AST_RST_ZERO: assert property ($rose(system_reset_req) |->
        $past(count_value) == 8'h00 || $past(count_value, 2) == 8'h00) else $error("reset without underflow");
    AST_RST_MODE: assert property (system_reset_req |-> $past(mode_reg)) else $error("reset in interval mode");
    AST_IRQ_MODE: assert property ($rose(interval_irq) |-> !$past(mode_reg)) else $error("flag in reset mode");
    AST_IRQ_HOLD: assert property (interval_irq && !flag_clear |=> interval_irq) else $error("flag lost");
    AST_IRQ_CLEAR: assert property ($fell(interval_irq) |-> $past(flag_clear)) else $error("flag fell alone");
    AST_STEP: assert property ($changed(count_value) && $past(count_value) != 8'h00 && !$past(feed_strobe)
        |-> count_value == $past(count_value) - 8'h01) else $error("counter step not minus one");
    AST_FEED: assert property (feed_strobe && feed_data == 8'h5A && $past(feed_strobe) &&
        $past(feed_data) == 8'hA5 |=> count_value == $past(reload_reg)) else $error("feed did not reload");
    AST_HALT: assert property (power_down && !running |-> $stable(count_value) && !system_reset_req)
        else $error("counting while halted");

    cover property (system_reset_req);
    cover property ($rose(interval_irq));
    cover property (power_down && !running);
endmodule

bind watchdog_interval_timer wdt_checker i_wdt_checker (.sys_clk, .rst_n, .power_down,
    .watchdog_reset_mode_enable, .reload_value, .cfg_write, .feed_strobe, .feed_data,
    .flag_clear, .system_reset_req, .interval_irq, .count_value, .running);

`default_nettype wire

// ===== sim/tb.sv
/*
  Self-checking bench for the watchdog / interval timer.
  Assumes the package and the timer are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
    import wdt_pkg::*;
    logic       sys_clk, rst_n, core_clk_tick, wdosc_pin, power_down, watchdog_reset_mode_enable;
    logic       osc_sel, cfg_write, feed_strobe, flag_clear, system_reset_req, interval_irq, running;
    logic [3:0] tap_sel;
    logic [7:0] reload_value, feed_data, count_value, v;
    int         n_errors = 0, n_checks = 0, n_rst = 0, r0 = 0, gap;

    watchdog_interval_timer i_watchdog_interval_timer (.sys_clk, .rst_n, .core_clk_tick, .wdosc_pin,
        .power_down, .watchdog_reset_mode_enable, .osc_sel, .tap_sel, .reload_value, .cfg_write,
        .feed_strobe, .feed_data, .flag_clear, .system_reset_req, .interval_irq, .count_value, .running);

    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // 400 kHz oscillator, phase unrelated to sys_clk
    initial begin
        wdosc_pin = 0;
        #7;
        forever #1250 wdosc_pin = ~wdosc_pin;
    end
    always @(posedge sys_clk) if (system_reset_req === 1'b1) n_rst <= n_rst + 1;

    task automatic results;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cfg(input logic m, input logic o, input logic [3:0] t, input logic [7:0] r);
        {watchdog_reset_mode_enable, osc_sel, tap_sel, reload_value, cfg_write} = {m, o, t, r, 1'b1};
        cyc(1);
        cfg_write = 0;
    endtask
    // two strobes back to back, then a quiet cycle
    task automatic feed(input logic [7:0] a, input logic [7:0] b);
        feed_strobe = 1;
        feed_data = a;
        cyc(1);
        feed_data = b;
        cyc(1);
        feed_strobe = 0;
        cyc(1);
    endtask
    task automatic gap_of(output int g);
        int i;
        for (i = 0; i < 2 && g < 900; i++) begin
            v = count_value;
            g = 0;
            while (count_value === v && g < 900) begin
                cyc(1);
                g++;
            end
        end
    endtask

    initial begin
        #(25 * 20000);
        n_errors++;
        results();
    end

    initial begin
        {rst_n, core_clk_tick, power_down, watchdog_reset_mode_enable, osc_sel, cfg_write} = '0;
        {feed_strobe, flag_clear, tap_sel, reload_value, feed_data} = '0;
        cyc(8);
        rst_n = 1;
        core_clk_tick = 1;
        chk(count_value, 8'hFF, "reset count");
        chk({interval_irq, system_reset_req}, 8'h00, "reset outputs");
        for (int t = 0; t < 3; t++) begin
            cfg(0, 0, t[3:0], 8'hFF);
            gap_of(gap);
            chk(gap[7:0], 8'h04 << t, "step period");
        end
        cfg(0, 0, 4'h0, 8'h40);
        feed(8'hA5, 8'h5A);
        chk(count_value, 8'h40, "feed reload");
        cyc(12);
        feed(8'hA5, 8'h00);
        feed(8'h5A, 8'h5A);
        // a good feed left 40 and it has stepped since; a wrongly taken feed would show 3F or 40
        chk({7'h0, count_value < 8'h3E}, 8'h01, "broken feed");
        cfg(0, 0, 4'h0, 8'h02);
        // new reload only lands on a feed or an underflow, so feed to start from it
        feed(8'hA5, 8'h5A);
        cyc(40);
        chk({7'h0, interval_irq}, 8'h01, "interval flag");
        cfg(0, 0, 4'hB, 8'h02);
        flag_clear = 1;
        cyc(1);
        flag_clear = 0;
        cyc(1);
        chk({interval_irq, 7'h0}, 8'h00, "flag clear");
        chk(n_rst[7:0], 8'h00, "no reset in interval mode");
        cfg(1, 0, 4'h0, 8'h03);
        feed(8'hA5, 8'h5A);
        r0 = n_rst;
        repeat (6) feed(8'hA5, 8'h5A);
        chk(8'(n_rst - r0), 8'h00, "fed watchdog quiet");
        // reload 3 at tap 0: four steps of four cycles, one underflow in 20 cycles
        cyc(20);
        chk(8'(n_rst - r0), 8'h01, "unfed watchdog resets");
        chk({7'h0, interval_irq}, 8'h00, "no flag in reset mode");
        power_down = 1;
        cyc(2);
        r0 = n_rst;
        v = count_value;
        cyc(40);
        chk(count_value, v, "frozen in power-down");
        chk({running, 7'(n_rst - r0)}, 8'h00, "halted, no reset");
        cfg(1, 1, 4'h0, 8'h01);
        // oscillator ticks every 100 cycles, tap 0 steps every 200: four or five steps
        cyc(900);
        chk({running, 7'h0}, 8'h80, "oscillator keeps running");
        chk({7'h0, n_rst != r0}, 8'h01, "oscillator underflow resets");
        results();
    end
endmodule

`default_nettype wire
